/* rtl/lsq_fifo.sv */
`timescale 1ns/1ps
module lsq_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // streams
  lsq_stream_if.snk                   wr,
  lsq_stream_if.src                   rd,
  // fill level, output register included
  output logic [$clog2(DEPTH):0]      level
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   mcnt;
  logic          ov;
  logic [W-1:0]  dout;
  logic          push;
  logic          pop;
  logic          load;

  // ****************************************
  // handshakes
  // ****************************************
  assign wr.ready = (level < (AW+1)'(DEPTH));
  assign rd.valid = ov;
  assign rd.data  = dout;
  assign push     = wr.valid && wr.ready;
  assign pop      = ov && rd.ready;
  // refill the output register whenever it frees up
  assign load     = (mcnt != '0) && (!ov || pop);

  // storage, no reset needed on the array
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp] <= wr.data;
    if (load)
      dout <= mem[rp];
  end

  // pointers and counts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp    <= '0;
      rp    <= '0;
      mcnt  <= '0;
      ov    <= 1'b0;
      level <= '0;
    end
    else
    begin
      wp    <= wp + AW'(push);
      rp    <= rp + AW'(load);
      mcnt  <= mcnt + (AW+1)'(push) - (AW+1)'(load);
      ov    <= load ? 1'b1 : (pop ? 1'b0 : ov);
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // a drained store writes its next word where the reader stands
  a_wr_at_rd: assert property (@(posedge clk) disable iff (!rst_n)
    (level == '0) && push |=> (rp == $past(wp)) && (mem[rp] == $past(wr.data)))
    else $error("word into a drained store not at the read pointer");

endmodule : lsq_fifo

/* rtl/lsq_pkg.sv */
package lsq_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_NS = 40;
  // pulse width, dark gap and rise-to-rise spacing per width setting, in us
  localparam int unsigned PW_US  [4] = '{69, 118, 215, 411};
  localparam int unsigned GAP_US [4] = '{358, 407, 505, 696};
  localparam int unsigned SPC_US [4] = '{427, 525, 720, 1107};
  // die temperature conversion time and sample period, in us
  localparam int unsigned TEMP_US = 30;
  localparam int unsigned SMP_US  = 1000;

  // least time rounds up to whole cycles
  function automatic int unsigned us2cyc(input int unsigned us);
    return (us * 1000 + CLK_NS - 1) / CLK_NS;
  endfunction : us2cyc

  localparam int unsigned PW_CYC_DEF  [4] = '{us2cyc(PW_US[0]), us2cyc(PW_US[1]),
                                              us2cyc(PW_US[2]), us2cyc(PW_US[3])};
  localparam int unsigned GAP_CYC_DEF [4] = '{us2cyc(GAP_US[0]), us2cyc(GAP_US[1]),
                                              us2cyc(GAP_US[2]), us2cyc(GAP_US[3])};
  localparam int unsigned SPC_CYC_DEF [4] = '{us2cyc(SPC_US[0]), us2cyc(SPC_US[1]),
                                              us2cyc(SPC_US[2]), us2cyc(SPC_US[3])};
  localparam int unsigned SMP_CYC_DEF = us2cyc(SMP_US);
  localparam logic [15:0] TEMP_CYC    = 16'(us2cyc(TEMP_US));

  // ****************************************
  // modes, widths, reset values
  // ****************************************
  localparam logic [2:0] MODE_SINGLE = 3'h2;
  localparam logic [2:0] MODE_DUAL   = 3'h3;
  localparam logic [2:0] MODE_MULTI  = 3'h7;
  localparam logic [2:0] MODE_RST    = 3'h0;
  localparam int NSLOT      = 3;
  localparam int SMP_W      = 18;
  localparam int SMP_FW     = NSLOT * SMP_W;
  localparam int TEMP_W     = 12;
  localparam int FIFO_DEPTH = 32;
  localparam int LVL_W      = 6;
  localparam int CNT_W      = 16;
  localparam logic [1:0] SLOT_NONE = 2'h3;
  localparam logic RSEL_TEMP = 1'b0;
  localparam logic RSEL_FIFO = 1'b1;

  typedef enum logic [2:0] {S_IDLE, S_PULSE, S_GAP, S_STORE, S_WAIT} lsq_state_t;

endpackage : lsq_pkg

/* rtl/lsq_sequencer.sv */
`timescale 1ns/1ps
module lsq_sequencer #(
  parameter int unsigned PW_CYC  [4] = lsq_pkg::PW_CYC_DEF,
  parameter int unsigned GAP_CYC [4] = lsq_pkg::GAP_CYC_DEF,
  parameter int unsigned SPC_CYC [4] = lsq_pkg::SPC_CYC_DEF,
  parameter int unsigned SMP_CYC     = lsq_pkg::SMP_CYC_DEF
) (
  // clock and reset
  input  wire logic                        CLK,
  input  wire logic                        NRST,
  // static configuration
  input  wire logic [1:0]                  PW_SEL,
  input  wire logic [2:0]                  SLOT_EN,
  input  wire logic [lsq_pkg::LVL_W-1:0]   AFULL_THR,
  input  wire logic                        IE_TEMP,
  input  wire logic                        IE_AFULL,
  input  wire logic                        IE_DRDY,
  // analog front end
  input  wire logic [lsq_pkg::SMP_W-1:0]   SMP_DATA,
  input  wire logic [lsq_pkg::TEMP_W-1:0]  TEMP_RAW,
  output logic      [2:0]                  LED_ON,
  // status
  output logic      [2:0]                  MODE_ACT,
  output logic                             TEMP_EN,
  output logic                             FLAG_TEMP,
  output logic                             FLAG_AFULL,
  output logic                             FLAG_DRDY,
  output logic      [lsq_pkg::LVL_W-1:0]   FIFO_LVL,
  // open-drain interrupt pin
  output logic                             INT_O,
  output logic                             INT_OE,
  // host link
  input  wire logic                        LCLK,
  input  wire logic                        L_WR,
  input  wire logic [2:0]                  L_MODE,
  input  wire logic                        L_TEMP_EN,
  input  wire logic                        L_RD,
  input  wire logic                        L_RSEL,
  output logic                             L_RBUSY,
  output logic                             L_RVALID,
  output logic                             L_REMPTY,
  output logic      [lsq_pkg::SMP_FW-1:0]  L_RDATA
);
  import lsq_pkg::*;

  lsq_state_t               st;
  logic [1:0]               slot;
  logic [1:0]               nslot;
  logic [1:0]               pw_q;
  logic [2:0]               act;
  logic [2:0]               act_q;
  logic [CNT_W-1:0]         cnt;
  logic [CNT_W-1:0]         per_cnt;
  logic                     per_done;
  logic                     pulse_end;
  logic [SMP_FW-1:0]        smp_buf;
  logic [CNT_W-1:0]         temp_cnt;
  logic                     temp_done;
  logic [TEMP_W-1:0]        temp_val;
  logic                     afull_now;
  logic                     afull_q;
  logic                     pending;
  // link-side registers
  logic                     wr_tgl;
  logic [2:0]               wr_mode_l;
  logic                     wr_ten_l;
  logic                     rd_tgl;
  logic                     rd_sel_l;
  logic                     ack_s1;
  logic                     ack_s2;
  logic                     ack_s3;
  logic                     ack_go;
  // core-side crossing registers
  logic                     wr_s1;
  logic                     wr_s2;
  logic                     wr_s3;
  logic                     rd_s1;
  logic                     rd_s2;
  logic                     rd_s3;
  logic                     wr_go;
  logic                     rd_go;
  logic                     rd_temp;
  logic                     rd_fifo;
  logic                     ack_tgl;
  logic [SMP_FW-1:0]        rd_word;
  logic                     rd_empty;

  lsq_stream_if #(.W(SMP_FW)) s_in ();
  lsq_stream_if #(.W(SMP_FW)) s_out ();

  // lowest active slot at or above a start index
  function automatic logic [1:0] first_slot(input logic [2:0] m, input logic [1:0] from);
    logic [1:0] r;
    r = SLOT_NONE;
    for (int i = NSLOT - 1; i >= 0; i--)
      if (m[i] && (2'(i) >= from))
        r = 2'(i);
    return r;
  endfunction : first_slot

  // ****************************************
  // host link domain
  // ****************************************

  // mode write: word held still while its toggle crosses over
  always_ff @(posedge LCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      wr_tgl    <= 1'b0;
      wr_mode_l <= MODE_RST;
      wr_ten_l  <= 1'b0;
    end
    else if (L_WR)
    begin
      wr_tgl    <= ~wr_tgl;
      wr_mode_l <= L_MODE;
      wr_ten_l  <= L_TEMP_EN;
    end
  end

  // read request: one outstanding, further requests ignored while busy
  always_ff @(posedge LCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rd_tgl   <= 1'b0;
      rd_sel_l <= RSEL_TEMP;
      L_RBUSY  <= 1'b0;
    end
    else if (L_RD && !L_RBUSY)
    begin
      rd_tgl   <= ~rd_tgl;
      rd_sel_l <= L_RSEL;
      L_RBUSY  <= 1'b1;
    end
    else if (ack_go)
      L_RBUSY <= 1'b0;
  end

  // answer toggle into the link clock
  always_ff @(posedge LCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
    end
    else
    begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end
  assign ack_go = ack_s2 ^ ack_s3;

  // answer word is stable in the core until the next request
  always_ff @(posedge LCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      L_RVALID <= 1'b0;
      L_REMPTY <= 1'b0;
      L_RDATA  <= '0;
    end
    else
    begin
      L_RVALID <= ack_go;
      if (ack_go)
      begin
        L_RDATA  <= rd_word;
        L_REMPTY <= rd_empty;
      end
    end
  end

  // ****************************************
  // crossings into the core clock
  // ****************************************
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      {wr_s1, wr_s2, wr_s3} <= 3'h0;
      {rd_s1, rd_s2, rd_s3} <= 3'h0;
    end
    else
    begin
      {wr_s1, wr_s2, wr_s3} <= {wr_tgl, wr_s1, wr_s2};
      {rd_s1, rd_s2, rd_s3} <= {rd_tgl, rd_s1, rd_s2};
    end
  end
  assign wr_go   = wr_s2 ^ wr_s3;
  assign rd_go   = rd_s2 ^ rd_s3;
  assign rd_temp = rd_go && (rd_sel_l == RSEL_TEMP);
  assign rd_fifo = rd_go && (rd_sel_l == RSEL_FIFO);

  // read service: pop a sample or return the temperature
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ack_tgl  <= 1'b0;
      rd_word  <= '0;
      rd_empty <= 1'b0;
    end
    else if (rd_go)
    begin
      ack_tgl  <= ~ack_tgl;
      rd_empty <= rd_fifo && !s_out.valid;
      rd_word  <= rd_fifo ? (s_out.valid ? s_out.data : '0) : SMP_FW'(temp_val);
    end
  end

  // ****************************************
  // mode register and temperature
  // ****************************************

  // mode takes effect at the next sample boundary
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      MODE_ACT <= MODE_RST;
    else if (wr_go)
      MODE_ACT <= wr_mode_l;
  end

  assign temp_done = TEMP_EN && (temp_cnt == TEMP_CYC - 16'd1);

  // a trigger while busy is dropped, so one write gives one result
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      TEMP_EN  <= 1'b0;
      temp_cnt <= '0;
      temp_val <= '0;
    end
    else if (temp_done)
    begin
      TEMP_EN  <= 1'b0;
      temp_val <= TEMP_RAW;
    end
    else if (TEMP_EN)
      temp_cnt <= temp_cnt + 16'd1;
    else if (wr_go && wr_ten_l)
    begin
      TEMP_EN  <= 1'b1;
      temp_cnt <= '0;
    end
  end

  // ****************************************
  // slot sequencer
  // ****************************************
  always_comb
  begin
    unique case (MODE_ACT)
      MODE_SINGLE: act = 3'b001;
      MODE_DUAL:   act = 3'b011;
      MODE_MULTI:  act = SLOT_EN;
      default:     act = 3'b000;
    endcase
  end

  assign nslot     = first_slot(act_q, 2'(slot + 2'd1));
  assign pulse_end = (st == S_PULSE) && (cnt == CNT_W'(PW_CYC[pw_q] - 1));
  assign per_done  = (per_cnt >= CNT_W'(SMP_CYC - 1));

  // pulse, gap, next pulse; settings latched once per sample
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st     <= S_IDLE;
      slot   <= 2'h0;
      cnt    <= '0;
      act_q  <= 3'h0;
      pw_q   <= 2'h0;
      LED_ON <= 3'h0;
    end
    else
    begin
      unique case (st)
        S_IDLE:
          if (|act)
          begin
            act_q  <= act;
            pw_q   <= PW_SEL;
            slot   <= first_slot(act, 2'h0);
            cnt    <= '0;
            LED_ON <= 3'h1 << first_slot(act, 2'h0);
            st     <= S_PULSE;
          end
        S_PULSE:
          if (pulse_end)
          begin
            cnt    <= '0;
            LED_ON <= 3'h0;
            if (nslot != SLOT_NONE)
            begin
              slot <= nslot;
              st   <= S_GAP;
            end
            else
              st <= S_STORE;
          end
          else
            cnt <= cnt + 16'd1;
        S_GAP:
          if (cnt == CNT_W'(GAP_CYC[pw_q] - 1))
          begin
            cnt    <= '0;
            LED_ON <= 3'h1 << slot;
            st     <= S_PULSE;
          end
          else
            cnt <= cnt + 16'd1;
        S_STORE:
          if (s_in.ready)
            st <= S_WAIT;
        S_WAIT:
          if (per_done)
            st <= S_IDLE;
      endcase
    end
  end

  // sample period measured from the first pulse
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      per_cnt <= '0;
    else if (st == S_IDLE)
      per_cnt <= '0;
    else if (!per_done)
      per_cnt <= per_cnt + 16'd1;
  end

  // per-slot capture of the converted value at pulse end
  for (genvar g = 0; g < NSLOT; g++)
  begin : g_cap
    always_ff @(posedge CLK or negedge NRST)
    begin
      if (!NRST)
        smp_buf[g*SMP_W +: SMP_W] <= '0;
      else if (st == S_IDLE)
        smp_buf[g*SMP_W +: SMP_W] <= '0;
      else if (pulse_end && (slot == 2'(g)))
        smp_buf[g*SMP_W +: SMP_W] <= SMP_DATA;
    end
  end

  // ****************************************
  // sample store
  // ****************************************
  assign s_in.valid  = (st == S_STORE);
  assign s_in.data   = smp_buf;
  assign s_out.ready = rd_fifo;

  // a full store stalls the sequencer rather than drop samples
  lsq_fifo #(
    .W     (SMP_FW),
    .DEPTH (FIFO_DEPTH)
  ) u_store (
    .clk   (CLK),
    .rst_n (NRST),
    .wr    (s_in),
    .rd    (s_out),
    .level (FIFO_LVL)
  );

  // ****************************************
  // event flags and interrupt pin
  // ****************************************
  assign afull_now = (AFULL_THR != '0) && (FIFO_LVL >= AFULL_THR);

  // set wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      FLAG_TEMP  <= 1'b0;
      FLAG_AFULL <= 1'b0;
      FLAG_DRDY  <= 1'b0;
      afull_q    <= 1'b0;
    end
    else
    begin
      afull_q    <= afull_now;
      FLAG_TEMP  <= temp_done || (FLAG_TEMP && !rd_temp);
      FLAG_AFULL <= (afull_now && !afull_q) || (FLAG_AFULL && !rd_fifo);
      FLAG_DRDY  <= (s_in.valid && s_in.ready) || (FLAG_DRDY && !rd_fifo);
    end
  end

  assign pending = (FLAG_TEMP && IE_TEMP) || (FLAG_AFULL && IE_AFULL)
                || (FLAG_DRDY && IE_DRDY);

  // pin pulled low while any enabled cause stays pending
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      INT_OE <= 1'b0;
      INT_O  <= 1'b0;
    end
    else
    begin
      INT_OE <= pending;
      INT_O  <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic              led_q;
  logic [CNT_W-1:0]  hi_len;
  logic [CNT_W-1:0]  lo_len;
  logic [CNT_W-1:0]  rr_len;

  // lengths of light, dark and rise-to-rise
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      led_q  <= 1'b0;
      hi_len <= '0;
      lo_len <= '0;
      rr_len <= '0;
    end
    else
    begin
      led_q  <= |LED_ON;
      hi_len <= (|LED_ON) ? hi_len + 16'd1 : '0;
      lo_len <= (|LED_ON) ? '0 : lo_len + 16'd1;
      rr_len <= ((|LED_ON) && !led_q) ? 16'd1 : rr_len + 16'd1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_pulse_len: assert property ($fell(|LED_ON) |-> hi_len == CNT_W'(PW_CYC[pw_q]))
    else $error("pulse length off the width setting");
  a_gap_len: assert property ($rose(|LED_ON) && $past(st) == S_GAP
    |-> lo_len == CNT_W'(GAP_CYC[pw_q]))
    else $error("dark gap between slots wrong");
  a_rise_space: assert property ($rose(|LED_ON) && $past(st) == S_GAP
    |-> rr_len == CNT_W'(SPC_CYC[pw_q]))
    else $error("rise to rise spacing wrong");
  a_store_stall: assert property (st == S_STORE && FIFO_LVL == LVL_W'(FIFO_DEPTH)
    |=> st == S_STORE)
    else $error("sample pushed into a full store");
  a_temp_once: assert property (TEMP_EN && !temp_done
    |=> TEMP_EN && temp_cnt == $past(temp_cnt) + 16'd1)
    else $error("conversion restarted or stopped early");
  a_temp_flag: assert property ($fell(TEMP_EN) |-> FLAG_TEMP ##1 INT_OE || !IE_TEMP)
    else $error("conversion end without temp flag");
  a_temp_clear: assert property (rd_temp && !temp_done |=> !FLAG_TEMP)
    else $error("temp flag kept after read");
  a_temp_selfclr: assert property (temp_done |=> !TEMP_EN)
    else $error("trigger bit not cleared");
  a_afull_set: assert property (afull_now && !afull_q |=> FLAG_AFULL)
    else $error("almost full not raised");
  a_afull_clear: assert property (rd_fifo && !(afull_now && !afull_q) |=> !FLAG_AFULL)
    else $error("almost full kept after read");
  a_int_level: assert property (##1 INT_OE == $past(pending))
    else $error("interrupt pin does not follow pending causes");

  c_temp_done:  cover property (temp_done);
  c_afull:      cover property (afull_now && !afull_q);
  c_three_slot: cover property (st == S_STORE && act_q == 3'b111);
  c_full_stall: cover property (st == S_STORE && !s_in.ready);

endmodule : lsq_sequencer

/* rtl/lsq_stream_if.sv */
`timescale 1ns/1ps
// valid/ready word stream between the sequencer and its sample store
interface lsq_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : lsq_stream_if

/* testbench/lsq_host.sv */
`timescale 1ns/1ps
// host end of the link: one request at a time, stale fields flipped
module lsq_host (
  // link
  input  wire logic        lclk,
  input  wire logic        l_rvalid,
  output logic             l_wr,
  output logic [2:0]       l_mode,
  output logic             l_temp_en,
  output logic             l_rd,
  output logic             l_rsel,
  // wait ran out
  output logic             hung
);
  initial
  begin
    {l_wr, l_mode, l_temp_en, l_rd, l_rsel, hung} = '0;
  end

  // mode and trigger travel in one write; writes spaced 8 link cycles
  task automatic wr(input logic [2:0] m, input logic t);
    @(posedge lclk);
    l_wr      <= 1'b1;
    l_mode    <= m;
    l_temp_en <= t;
    @(posedge lclk);
    l_wr      <= 1'b0;
    l_mode    <= ~m;
    l_temp_en <= ~t;
    repeat (6) @(posedge lclk);
  endtask : wr

  // next request only from the link cycle after the answer
  task automatic rd(input logic s);
    int i;
    @(posedge lclk);
    l_rd   <= 1'b1;
    l_rsel <= s;
    @(posedge lclk);
    l_rd   <= 1'b0;
    l_rsel <= ~s;
    for (i = 0; i < 20 && l_rvalid !== 1'b1; i++) @(posedge lclk);
    if (l_rvalid !== 1'b1) hung <= 1'b1;
  endtask : rd
endmodule : lsq_host

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import lsq_pkg::*;
  localparam int unsigned PW [4] = '{4, 5, 6, 7};
  localparam int unsigned GP [4] = '{3, 4, 5, 6};
  localparam int unsigned SP [4] = '{7, 9, 11, 13};
  logic clk = 1'b0, lclk = 1'b0, nrst = 1'b0;
  logic [1:0] pw_sel = '0;
  logic [LVL_W-1:0] thr = '0;
  logic ie_t = 1'b0, ie_a = 1'b0, ie_d = 1'b0;
  logic [SMP_W-1:0] smp = '0;
  logic [TEMP_W-1:0] traw = '0;
  logic [2:0] led, mode, l_mode;
  logic [2:0] slot_en = 3'h7;
  logic int_o, f_d, l_busy;
  logic temp_en, f_t, f_a, int_oe, hung, l_wr, l_ten, l_rd, l_rsel, l_rv, l_re;
  logic [LVL_W-1:0] lvl;
  logic [SMP_FW-1:0] l_rdata;
  logic [SMP_FW:0] exp_q[$];
  logic [31:0] seed = 32'h2f819a89;
  int n_mismatch = 0, checks = 0, i, k, n;

  // ******************
  // clocks and blocks
  // ******************
  initial forever #20 clk = ~clk;
  // link clock out of phase with the core
  initial
  begin
    #7;
    forever #24 lclk = ~lclk;
  end

  lsq_sequencer #(.PW_CYC(PW), .GAP_CYC(GP), .SPC_CYC(SP), .SMP_CYC(40)) u_lsq_sequencer (
    .CLK(clk), .NRST(nrst), .PW_SEL(pw_sel), .SLOT_EN(slot_en), .AFULL_THR(thr),
    .IE_TEMP(ie_t), .IE_AFULL(ie_a), .IE_DRDY(ie_d), .SMP_DATA(smp), .TEMP_RAW(traw),
    .LED_ON(led), .MODE_ACT(mode), .TEMP_EN(temp_en), .FLAG_TEMP(f_t), .FLAG_AFULL(f_a),
    .FLAG_DRDY(f_d), .FIFO_LVL(lvl), .INT_O(int_o), .INT_OE(int_oe), .LCLK(lclk), .L_WR(l_wr),
    .L_MODE(l_mode), .L_TEMP_EN(l_ten), .L_RD(l_rd), .L_RSEL(l_rsel), .L_RBUSY(l_busy),
    .L_RVALID(l_rv), .L_REMPTY(l_re), .L_RDATA(l_rdata));

  lsq_host u_lsq_host (.lclk(lclk), .l_rvalid(l_rv), .l_wr(l_wr), .l_mode(l_mode),
    .l_temp_en(l_ten), .l_rd(l_rd), .l_rsel(l_rsel), .hung(hung));

  // ******************
  // checks
  // ******************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction : lfsr

  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    checks++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic hang();
    n_mismatch++;
    $display("mismatch at %0t: wait ran out", $time);
    close_out();
  endtask : hang

  // each answer is matched with the oldest note
  // an answer with no note left is itself a mismatch
  always @(posedge lclk)
    if (l_rv === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(1'b1, 1'b0);
      else
        chk({l_busy, l_re, l_rdata}, {1'b0, exp_q.pop_front()});
    end

  always @(posedge hung) hang();

  // ******************
  // sequence
  // ******************
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    seed = lfsr(seed);
    smp  <= seed[SMP_W-1:0];
    traw <= seed[31:20];
    ie_t <= 1'b1;
    ie_a <= 1'b1;
    ie_d <= 1'b0;
    thr  <= 6'd31;
    repeat (3) @(posedge clk);
    chk(int_oe, 1'b0);
    u_lsq_host.wr(MODE_DUAL, 1'b1);
    chk(mode, MODE_DUAL);
    chk(temp_en, 1'b1);
    $display("test mode write done");
    // width is latched per sample, so measure the second sample after a change
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      pw_sel <= 2'(i);
      repeat (2)
      begin
        for (k = 0; k < 99 && led === 3'h1; k++) @(posedge clk);
        for (k = 0; k < 99 && led !== 3'h1; k++) @(posedge clk);
      end
      for (n = 0; n < 50 && led === 3'h1; n++) @(posedge clk);
      for (k = 0; k < 50 && led === 3'h0; k++) @(posedge clk);
      chk(k, GP[i]);
      chk(n + k, SP[i]);
      chk(led, 3'h2);
    end
    $display("test slot timing done");
    for (k = 0; k < 900 && temp_en !== 1'b0; k++) @(posedge clk);
    if (temp_en !== 1'b0) hang();
    repeat (2) @(posedge clk);
    chk(f_t, 1'b1);
    chk({int_oe, int_o}, 2'b10);
    repeat (100) @(posedge clk);
    chk(temp_en, 1'b0);
    $display("test temperature done");
    for (k = 0; k < 2000 && f_a !== 1'b1; k++) @(posedge clk);
    if (f_a !== 1'b1) hang();
    chk(lvl, 6'd31);
    for (k = 0; k < 200 && lvl !== 6'd32; k++) @(posedge clk);
    repeat (100) @(posedge clk);
    chk(lvl, 6'd32);
    exp_q.push_back({1'b0, 42'h0, traw});
    u_lsq_host.rd(RSEL_TEMP);
    repeat (3) @(posedge clk);
    chk(f_t, 1'b0);
    chk(int_oe, 1'b1);
    exp_q.push_back({1'b0, 18'h0, smp, smp});
    u_lsq_host.rd(RSEL_FIFO);
    repeat (3) @(posedge clk);
    chk({f_a, int_oe}, 2'b00);
    $display("test interrupt done");
    // stop sampling, then empty the store
    u_lsq_host.wr(MODE_RST, 1'b0);
    repeat (60) @(posedge clk);
    for (i = 0; i < 40 && lvl !== 6'd0; i++)
    begin
      exp_q.push_back({1'b0, 18'h0, smp, smp});
      u_lsq_host.rd(RSEL_FIFO);
    end
    exp_q.push_back({1'b1, 54'h0});
    u_lsq_host.rd(RSEL_FIFO);
    chk(lvl, 6'd0);
    chk(f_d, 1'b0);
    @(posedge clk);
    seed = lfsr(seed);
    smp <= seed[SMP_W-1:0];
    u_lsq_host.wr(MODE_SINGLE, 1'b0);
    for (k = 0; k < 200 && lvl !== 6'd1; k++) @(posedge clk);
    if (lvl !== 6'd1) hang();
    chk({f_d, int_oe}, 2'b10);
    exp_q.push_back({1'b0, 36'h0, smp});
    u_lsq_host.rd(RSEL_FIFO);
    repeat (4) @(posedge lclk);
    chk(exp_q.size(), 0);
    $display("test store drain done");
    // slot 1 switched off: the gap runs straight from slot 0 to slot 2
    @(posedge clk);
    slot_en <= 3'h5;
    u_lsq_host.wr(MODE_MULTI, 1'b0);
    repeat (2)
    begin
      for (k = 0; k < 99 && led === 3'h1; k++) @(posedge clk);
      for (k = 0; k < 99 && led !== 3'h1; k++) @(posedge clk);
    end
    for (n = 0; n < 50 && led === 3'h1; n++) @(posedge clk);
    for (k = 0; k < 50 && led === 3'h0; k++) @(posedge clk);
    chk(k, GP[3]);
    chk(n + k, SP[3]);
    chk(led, 3'h4);
    $display("test multi slot done");
    close_out();
  end
endmodule : testbench
